// *** logic/pfta_map.vh ***
// Register map, field positions and timing constants of the flash sequencer
`ifndef PFTA_MAP_VH
`define PFTA_MAP_VH

// Word register addresses, bus address bits 4:2
`define PFTA_REG_PTR      3'h0
`define PFTA_REG_LATCH    3'h1
`define PFTA_REG_CTRL     3'h2
`define PFTA_REG_UNLOCK   3'h3
`define PFTA_REG_TBLOP    3'h4
`define PFTA_REG_ISTAT    3'h5
`define PFTA_REG_IMASK    3'h6

// Control register fields
`define PFTA_CTRL_FLASH   7
`define PFTA_CTRL_CFG     6
`define PFTA_CTRL_ERASE   4
`define PFTA_CTRL_ABORT   3
`define PFTA_CTRL_ALLOW   2
`define PFTA_CTRL_GO      1

// Table operation register fields
`define PFTA_OP_STORE     0
`define PFTA_OP_VAR_HI    2
`define PFTA_OP_VAR_LO    1
`define PFTA_OP_BUSY      0

// Pointer update variants
`define PFTA_VAR_NONE     2'h0
`define PFTA_VAR_POSTINC  2'h1
`define PFTA_VAR_POSTDEC  2'h2
`define PFTA_VAR_PREINC   2'h3

// Interrupt status fields
`define PFTA_IRQ_DONE     0
`define PFTA_IRQ_BADGO    1

// Unlock sequence
`define PFTA_KEY_FIRST    8'h55
`define PFTA_KEY_SECOND   8'hAA
`define PFTA_UNL_IDLE     2'h0
`define PFTA_UNL_FIRST    2'h1
`define PFTA_UNL_ARMED    2'h2

// Reset values and the pointer step
`define PFTA_HOLD_RESET   8'hFF
`define PFTA_PTR_RESET    22'h00_0000
`define PFTA_LSB_ONE      21'h00_0001

// Long cycle timing
`define PFTA_LONG_TIME_US 2000
`define PFTA_CLK_MHZ      10

`endif

// *** logic/pfta_hold.v ***
// Eight byte-wide programming holding registers
`timescale 1ns/100ps
module pfta_hold
(
  input  wire        mclk_in,
  input  wire        resetn_in,
  input  wire        wr_en_in,
  input  wire [2:0]  wr_idx_in,
  input  wire [7:0]  wr_data_in,
  input  wire        clear_in,
  output wire [63:0] data_out
);
`include "pfta_map.vh"

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_byte
      reg [7:0] hold;
      always @(posedge mclk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          hold <= `PFTA_HOLD_RESET; // R13
        else if (clear_in)
          hold <= `PFTA_HOLD_RESET; // R13
        else if (wr_en_in && (wr_idx_in == g))
          hold <= wr_data_in; // R11
      end
      assign data_out[8*g+7:8*g] = hold;
    end
  endgenerate

endmodule // pfta_hold

// *** logic/pfta_ctrl.v ***
// Flash table access, unlock and self-timed erase/program sequencer
//Contract
// R1 - Fetch moves one addressed byte into latch
// R2 - Pointer adjusts after fetch per variant
// R3 - Pointer bit 0 picks low/high byte
// R4 - Erase always clears a 64-byte row
// R5 - Erase row from pointer bits 21:6
// R6 - Software sets space, allow, erase before erase
// R7 - Software unlocks 55h then AAh then go
// R8 - Long cycle halts CPU, ends by timer
// R9 - Row erase stalls about 2 ms
// R10 - Programming always acts on 8 bytes
// R11 - Store loads holding registers only
// R12 - Software starts program via control write
// R13 - Holding registers reset to FFh
// R14 - FFh holding byte leaves flash unchanged
// R15 - Program block from pointer bits 21:3
// R16 - Hardware clears go and erase enable
// R17 - Completion sets done flag, software clears
// R18 - Abort flag on reset or bad start
// R19 - Go accepted only right after unlock
`timescale 1ns/100ps
`include "pfta_map.vh"
module pfta_ctrl
#(
  parameter LONG_CYCLES = `PFTA_LONG_TIME_US * `PFTA_CLK_MHZ
)
(
  input  wire        mclk_in,
  input  wire        resetn_in,
  input  wire        por_resetn_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire [15:0] flash_rdata_in,
  output reg  [20:0] flash_addr_out,
  output reg         flash_rd_out,
  output reg         flash_erase_out,
  output reg         flash_prog_out,
  output wire [63:0] flash_wdata_out,
  output reg         cpu_stall_out,
  output reg         irq_out
);

  // ==========================================================
  // State encoding
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RDW  = 4'h2;
  localparam [3:0] ST_RDC  = 4'h4;
  localparam [3:0] ST_LONG = 4'h8;
  // Timer is 16 bits wide, so the last count is cut to match
  localparam integer LONG_SPAN = LONG_CYCLES - 1;
  localparam [15:0] LONG_LAST = LONG_SPAN[15:0];

  reg  [3:0]  state;
  reg  [21:0] table_pointer;
  reg  [7:0]  table_byte_latch;
  reg         program_allow;
  reg         row_erase_en;
  reg         go;
  reg  [1:0]  unlock_stage;
  reg         long_erase;
  reg  [15:0] timer;
  reg  [1:0]  irq_stat;
  reg  [1:0]  irq_mask;
  reg         byte_sel;
  reg         run_seen;
  // Power-on domain: survives a device reset for tracing
  reg         flash_space_select;
  reg         config_space_select;
  reg         aborted_cycle_flag;
  reg         busy_shadow;

  reg  [31:0] next_rdata;

  // ==========================================================
  // Request decode
  wire        req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire        idle    = state[0];
  wire [2:0]  reg_sel = wb_adr_in[4:2];
  wire        wr_any  = req & idle & wb_we_in;
  wire        wr_b0   = wr_any & wb_sel_in[0];
  wire        ctrl_wr = wr_b0 & (reg_sel == `PFTA_REG_CTRL);
  wire        op_wr   = wr_b0 & (reg_sel == `PFTA_REG_TBLOP);
  wire        unl_wr  = wr_b0 & (reg_sel == `PFTA_REG_UNLOCK);
  wire [1:0]  req_var = wb_dat_in[`PFTA_OP_VAR_HI:`PFTA_OP_VAR_LO];
  wire        is_store = wb_dat_in[`PFTA_OP_STORE];

  // Pointer arithmetic touches the low 21 bits only
  wire [21:0] ptr_inc = {table_pointer[21],
                         table_pointer[20:0] + `PFTA_LSB_ONE};
  wire [21:0] ptr_dec = {table_pointer[21],
                         table_pointer[20:0] - `PFTA_LSB_ONE};
  wire [21:0] eff_ptr = (req_var == `PFTA_VAR_PREINC) ? ptr_inc
                                                      : table_pointer;
  wire [21:0] next_ptr = (req_var == `PFTA_VAR_NONE)    ? table_pointer :
                         (req_var == `PFTA_VAR_POSTDEC) ? ptr_dec
                                                        : ptr_inc; // R2

  // Go needs the armed unlock and a sane flash-space setup
  wire go_req  = ctrl_wr & wb_dat_in[`PFTA_CTRL_GO];
  wire go_ok   = (unlock_stage == `PFTA_UNL_ARMED) // R19
               & wb_dat_in[`PFTA_CTRL_ALLOW]
               & wb_dat_in[`PFTA_CTRL_FLASH]
               & ~wb_dat_in[`PFTA_CTRL_CFG]; // R6
  wire start_long = go_req & go_ok & ~go; // R7
  wire bad_go     = go_req & ~go & ~go_ok; // R18
  wire end_long   = state[3] & (timer == LONG_LAST); // R8
  wire store_now  = op_wr & is_store;
  wire reset_abort = ~run_seen & busy_shadow; // R18

  pfta_hold u_hold
  (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .wr_en_in   (store_now), // R11
    .wr_idx_in  (eff_ptr[2:0]),
    .wr_data_in (table_byte_latch),
    .clear_in   (end_long & ~long_erase), // R13
    .data_out   (flash_wdata_out) // R14
  );

  // ==========================================================
  // Read data mux
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (reg_sel)
      `PFTA_REG_PTR:   next_rdata[21:0] = table_pointer;
      `PFTA_REG_LATCH: next_rdata[7:0]  = table_byte_latch;
      `PFTA_REG_CTRL:
      begin
        next_rdata[`PFTA_CTRL_FLASH] = flash_space_select;
        next_rdata[`PFTA_CTRL_CFG]   = config_space_select;
        next_rdata[`PFTA_CTRL_ERASE] = row_erase_en;
        next_rdata[`PFTA_CTRL_ABORT] = aborted_cycle_flag;
        next_rdata[`PFTA_CTRL_ALLOW] = program_allow;
        next_rdata[`PFTA_CTRL_GO]    = go;
      end
      `PFTA_REG_TBLOP: next_rdata[`PFTA_OP_BUSY] = ~idle;
      `PFTA_REG_ISTAT: next_rdata[1:0] = irq_stat;
      `PFTA_REG_IMASK: next_rdata[1:0] = irq_mask;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Bits kept across a device reset
  always @(posedge mclk_in or negedge por_resetn_in)
  begin
    if (!por_resetn_in)
    begin
      flash_space_select  <= 1'b0;
      config_space_select <= 1'b0;
      aborted_cycle_flag  <= 1'b0;
      busy_shadow         <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        flash_space_select  <= wb_dat_in[`PFTA_CTRL_FLASH];
        config_space_select <= wb_dat_in[`PFTA_CTRL_CFG];
      end
      if (reset_abort | bad_go)
        aborted_cycle_flag <= 1'b1; // R18
      else if (end_long)
        aborted_cycle_flag <= 1'b0;
      else if (ctrl_wr)
        aborted_cycle_flag <= wb_dat_in[`PFTA_CTRL_ABORT];
      if (start_long)
        busy_shadow <= 1'b1;
      else if (end_long | reset_abort)
        busy_shadow <= 1'b0;
    end
  end

  // ==========================================================
  // Main sequencer and register file
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state            <= ST_IDLE;
      table_pointer    <= `PFTA_PTR_RESET;
      table_byte_latch <= 8'h00;
      program_allow    <= 1'b0;
      row_erase_en     <= 1'b0;
      go               <= 1'b0;
      unlock_stage     <= `PFTA_UNL_IDLE;
      long_erase       <= 1'b0;
      timer            <= 16'h0000;
      irq_stat         <= 2'h0;
      irq_mask         <= 2'h0;
      byte_sel         <= 1'b0;
      run_seen         <= 1'b0;
      wb_dat_out       <= 32'h0000_0000;
      wb_ack_out       <= 1'b0;
      flash_addr_out   <= 21'h00_0000;
      flash_rd_out     <= 1'b0;
      flash_erase_out  <= 1'b0;
      flash_prog_out   <= 1'b0;
      cpu_stall_out    <= 1'b0;
      irq_out          <= 1'b0;
    end
    else
    begin
      run_seen        <= 1'b1;
      wb_ack_out      <= 1'b0;
      flash_rd_out    <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_prog_out  <= 1'b0;
      irq_out         <= |(irq_stat & irq_mask);

      // Any write other than the next key breaks the unlock chain
      if (wr_any)
      begin
        if (unl_wr && wb_dat_in[7:0] == `PFTA_KEY_FIRST)
          unlock_stage <= `PFTA_UNL_FIRST;
        else if (unl_wr && wb_dat_in[7:0] == `PFTA_KEY_SECOND &&
                 unlock_stage == `PFTA_UNL_FIRST)
          unlock_stage <= `PFTA_UNL_ARMED;
        else
          unlock_stage <= `PFTA_UNL_IDLE; // R19
      end

      // Sticky events: set beats the write-one clear
      irq_stat[`PFTA_IRQ_DONE]  <= end_long | (irq_stat[`PFTA_IRQ_DONE] &
        ~(wr_b0 && reg_sel == `PFTA_REG_ISTAT &&
          wb_dat_in[`PFTA_IRQ_DONE])); // R17
      irq_stat[`PFTA_IRQ_BADGO] <= bad_go | (irq_stat[`PFTA_IRQ_BADGO] &
        ~(wr_b0 && reg_sel == `PFTA_REG_ISTAT &&
          wb_dat_in[`PFTA_IRQ_BADGO]));

      case (state)
        ST_IDLE:
        begin
          if (req && !start_long && !(op_wr && !is_store))
          begin
            wb_ack_out <= 1'b1;
            wb_dat_out <= wb_we_in ? 32'h0000_0000 : next_rdata;
          end
          if (wr_any && reg_sel == `PFTA_REG_PTR)
          begin
            if (wb_sel_in[0])
              table_pointer[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1])
              table_pointer[15:8] <= wb_dat_in[15:8];
            if (wb_sel_in[2])
              table_pointer[21:16] <= wb_dat_in[21:16];
          end
          if (wr_b0 && reg_sel == `PFTA_REG_LATCH)
            table_byte_latch <= wb_dat_in[7:0];
          if (wr_b0 && reg_sel == `PFTA_REG_IMASK)
            irq_mask <= wb_dat_in[1:0];
          if (ctrl_wr)
          begin
            program_allow <= wb_dat_in[`PFTA_CTRL_ALLOW];
            row_erase_en  <= wb_dat_in[`PFTA_CTRL_ERASE];
          end
          if (store_now)
            table_pointer <= next_ptr; // R2
          if (op_wr && !is_store)
          begin
            flash_addr_out <= eff_ptr[21:1]; // R1
            byte_sel       <= eff_ptr[0]; // R3
            table_pointer  <= next_ptr; // R2
            flash_rd_out   <= 1'b1;
            state          <= ST_RDW;
          end
          if (start_long)
          begin
            go            <= 1'b1;
            long_erase    <= wb_dat_in[`PFTA_CTRL_ERASE];
            timer         <= 16'h0000;
            cpu_stall_out <= 1'b1; // R8
            if (wb_dat_in[`PFTA_CTRL_ERASE])
            begin
              flash_addr_out  <= {table_pointer[21:6], 5'h00}; // R5
              flash_erase_out <= 1'b1; // R4
            end
            else
            begin
              flash_addr_out <= {table_pointer[21:3], 2'h0}; // R15
              flash_prog_out <= 1'b1; // R10
            end
            state <= ST_LONG;
          end
        end
        ST_RDW:
          state <= ST_RDC;
        ST_RDC:
        begin
          table_byte_latch <= byte_sel ? flash_rdata_in[15:8]
                                       : flash_rdata_in[7:0]; // R3
          wb_ack_out <= 1'b1;
          wb_dat_out <= 32'h0000_0000;
          state      <= ST_IDLE;
        end
        ST_LONG:
        begin
          timer <= timer + 16'h0001; // R9
          if (end_long)
          begin
            go            <= 1'b0; // R16
            if (long_erase)
              row_erase_en <= 1'b0; // R16
            cpu_stall_out <= 1'b0;
            wb_ack_out    <= 1'b1; // R8
            wb_dat_out    <= 32'h0000_0000;
            state         <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // pfta_ctrl

// *** bench/pfta_flash_model.sv ***
// Behavioural flash array behind the sequencer
`timescale 1ns/100ps
module pfta_flash_model
(
  input  wire        mclk_in,
  input  wire        flash_rd_in,
  input  wire        flash_erase_in,
  input  wire        flash_prog_in,
  input  wire [20:0] flash_addr_in,
  input  wire [63:0] flash_wdata_in,
  output reg  [15:0] flash_rdata_out
);
  // ========================================
  // Array, 128 words seen through low address bits
  reg [15:0] mem [0:127];
  integer    k;
  initial
  begin
    for (k = 0; k < 128; k = k + 1)
      mem[k] = {~k[7:0], k[7:0]};
    flash_rdata_out = 16'h0000;
  end
  // Data only valid one cycle; toggling otherwise so stale reads show
  always @(posedge mclk_in)
  begin
    flash_rdata_out <= ~flash_rdata_out;
    if (flash_rd_in)
      flash_rdata_out <= mem[flash_addr_in[6:0]];
    if (flash_erase_in)
      for (k = 0; k < 32; k = k + 1)
        mem[{flash_addr_in[6:5], k[4:0]}] <= 16'hFFFF;
    if (flash_prog_in)
      for (k = 0; k < 4; k = k + 1)
        mem[{flash_addr_in[6:2], k[1:0]}] <=
          mem[{flash_addr_in[6:2], k[1:0]}] & flash_wdata_in[16*k +: 16];
  end
endmodule // pfta_flash_model

// *** bench/pfta_ctrl_properties.sv ***
// Port-level checks of the flash sequencer
`timescale 1ns/100ps
`include "pfta_map.vh"
module pfta_ctrl_chk
#(
  parameter LONG_CYCLES = 20
)
(
  input wire        mclk_in,
  input wire        resetn_in,
  input wire        wb_cyc_in,
  input wire        wb_we_in,
  input wire [7:0]  wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire        wb_ack_out,
  input wire [20:0] flash_addr_out,
  input wire        flash_rd_out,
  input wire        flash_erase_out,
  input wire        flash_prog_out,
  input wire        cpu_stall_out
);
  // ========================================
  // Stall length counter
  reg [15:0] stall_cnt;
  always @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      stall_cnt <= 16'h0000;
    else if (cpu_stall_out)
      stall_cnt <= stall_cnt + 16'h0001;
    else
      stall_cnt <= 16'h0000;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ========================================
  // Properties
  rd_single_a: assert property (flash_rd_out |=> !flash_rd_out)
    else $error("fetch read pulse too long");
  fetch_ack_a: assert property (flash_rd_out |-> ##2 wb_ack_out)
    else $error("fetch not answered two cycles after read");
  erase_row_a: assert property
    (flash_erase_out |-> !flash_addr_out[4:0])
    else $error("erase address not row aligned");
  prog_block_a: assert property
    (flash_prog_out |-> !flash_addr_out[1:0])
    else $error("program address not block aligned");
  stall_start_a: assert property
    ((flash_erase_out || flash_prog_out) |-> cpu_stall_out)
    else $error("long cycle began without stall");
  stall_quiet_a: assert property (cpu_stall_out |=>
    !flash_rd_out && !flash_erase_out && !flash_prog_out)
    else $error("flash activity during stall");
  stall_time_a: assert property
    ($fell(cpu_stall_out) |-> stall_cnt == LONG_CYCLES)
    else $error("stall length differs from timer");
  stall_end_a: assert property ($fell(cpu_stall_out) |-> wb_ack_out)
    else $error("go write not answered at end of stall");
  go_cause_a: assert property ((flash_erase_out || flash_prog_out) |->
    $past(wb_cyc_in && wb_we_in && wb_adr_in[4:2] == `PFTA_REG_CTRL
    && wb_dat_in[`PFTA_CTRL_GO]))
    else $error("long cycle without go write");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  cover property (flash_erase_out);
  cover property (flash_prog_out);
  cover property (flash_rd_out ##2 wb_ack_out);
endmodule // pfta_ctrl_chk

bind pfta_ctrl pfta_ctrl_chk #(.LONG_CYCLES(LONG_CYCLES)) pfta_ctrl_chk_i
(
  .mclk_in         (mclk_in),
  .resetn_in       (resetn_in),
  .wb_cyc_in       (wb_cyc_in),
  .wb_we_in        (wb_we_in),
  .wb_adr_in       (wb_adr_in),
  .wb_dat_in       (wb_dat_in),
  .wb_ack_out      (wb_ack_out),
  .flash_addr_out  (flash_addr_out),
  .flash_rd_out    (flash_rd_out),
  .flash_erase_out (flash_erase_out),
  .flash_prog_out  (flash_prog_out),
  .cpu_stall_out   (cpu_stall_out)
);

// *** bench/tb.sv ***
// Self-checking bench of the flash sequencer
`timescale 1ns/100ps
`include "pfta_map.vh"
module tb;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg         por  = 1'b0;
  reg         cyc  = 1'b0;
  reg         we   = 1'b0;
  reg  [7:0]  adr  = 8'h00;
  reg  [31:0] dat  = 32'h0000_0000;
  reg  [63:0] rd;
  reg  [53:0] rows [0:4];
  reg  [21:0] p;
  reg  [21:0] np;
  reg  [1:0]  v;
  reg  [7:0]  b;
  wire [31:0] dout;
  wire        ack;
  wire [15:0] frdata;
  wire [20:0] faddr;
  wire        frd;
  wire        fer;
  wire        fpr;
  wire [63:0] fwd;
  wire        stall;
  wire        irq;
  integer     i;
  integer     mismatches = 0;
  integer     n_tests = 0;

  always #50 mclk = ~mclk;

  pfta_ctrl #(.LONG_CYCLES(20)) pfta_ctrl_i
  (
    .mclk_in(mclk), .resetn_in(rstn), .por_resetn_in(por),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack),
    .flash_rdata_in(frdata), .flash_addr_out(faddr), .flash_rd_out(frd),
    .flash_erase_out(fer), .flash_prog_out(fpr), .flash_wdata_out(fwd),
    .cpu_stall_out(stall), .irq_out(irq)
  );
  pfta_flash_model pfta_flash_model_i
  (
    .mclk_in(mclk), .flash_rd_in(frd), .flash_erase_in(fer),
    .flash_prog_in(fpr), .flash_addr_in(faddr), .flash_wdata_in(fwd),
    .flash_rdata_out(frdata)
  );
  // ========================================
  // Tasks
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [79:0] nm, input [63:0] e, input [63:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Only the watchdog ends a wait for the answer
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      adr <= a;
      we <= w;
      dat <= d;
      cyc <= 1'b1;
      @(posedge mclk);
      while (ack !== 1'b1)
        @(posedge mclk);
      rd = {32'h0000_0000, dout};
      cyc <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task fetch(input [21:0] a, input [1:0] vv);
    begin
      wb(8'h00, 1'b1, {10'h000, a});
      wb(8'h10, 1'b1, {29'h0000_0000, vv, 1'b0});
      wb(8'h04, 1'b0, 32'h0000_0000);
    end
  endtask
  // Unlock keys go straight before the go write
  task go(input [7:0] c);
    begin
      wb(8'h08, 1'b1, {24'h00_0000, c});
      wb(8'h0C, 1'b1, {24'h00_0000, `PFTA_KEY_FIRST});
      wb(8'h0C, 1'b1, {24'h00_0000, `PFTA_KEY_SECOND});
      wb(8'h08, 1'b1, {24'h00_0000, c | 8'h02});
    end
  endtask
  initial
  begin
    #(3000 * 100);
    mismatches = mismatches + 1;
    test_done;
  end
  // ========================================
  // Sequence
  initial
  begin
    rows[0] = {22'h00_0010, `PFTA_VAR_NONE, 8'h08, 22'h00_0010};
    rows[1] = {22'h00_0011, `PFTA_VAR_POSTINC, 8'hF7, 22'h00_0012};
    rows[2] = {22'h00_0012, `PFTA_VAR_POSTDEC, 8'h09, 22'h00_0011};
    rows[3] = {22'h00_0012, `PFTA_VAR_PREINC, 8'hF6, 22'h00_0013};
    rows[4] = {22'h20_0000, `PFTA_VAR_POSTDEC, 8'h00, 22'h3F_FFFF};
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    por <= 1'b1;
    @(posedge mclk);
    chk("holding", 64'hFFFF_FFFF_FFFF_FFFF, fwd);
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk("control", 64'h0, rd);
    for (i = 0; i < 5; i = i + 1)
    begin
      {p, v, b, np} = rows[i];
      fetch(p, v);
      chk("latch", {56'h0, b}, rd);
      wb(8'h00, 1'b0, 32'h0000_0000);
      chk("pointer", {42'h0, np}, rd);
    end
    // Store one byte, program the block, done interrupt unmasked
    wb(8'h00, 1'b1, 32'h0000_0013);
    wb(8'h04, 1'b1, 32'h0000_003C);
    wb(8'h10, 1'b1, 32'h0000_0001);
    chk("holding", 64'hFFFF_FFFF_3CFF_FFFF, fwd);
    wb(8'h18, 1'b1, 32'h0000_0001);
    go(8'h84);
    chk("holding", 64'hFFFF_FFFF_FFFF_FFFF, fwd);
    chk("irq", 64'h1, {63'h0, irq});
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk("control", 64'h84, rd);
    fetch(22'h00_0013, `PFTA_VAR_NONE);
    chk("flash", 64'h34, rd);
    fetch(22'h00_0010, `PFTA_VAR_NONE);
    chk("flash", 64'h08, rd);
    wb(8'h14, 1'b1, 32'h0000_0003);
    chk("irq", 64'h0, {63'h0, irq});
    // Erase with interrupt masked, pointer low bits set
    wb(8'h18, 1'b1, 32'h0000_0000);
    wb(8'h00, 1'b1, 32'h0000_0025);
    go(8'h94);
    chk("irq", 64'h0, {63'h0, irq});
    wb(8'h14, 1'b0, 32'h0000_0000);
    chk("status", 64'h1, rd);
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk("control", 64'h84, rd);
    fetch(22'h00_0003, `PFTA_VAR_NONE);
    chk("flash", 64'hFF, rd);
    fetch(22'h00_0040, `PFTA_VAR_NONE);
    chk("flash", 64'h20, rd);
    // Broken unlock chain must be refused
    wb(8'h14, 1'b1, 32'h0000_0003);
    wb(8'h0C, 1'b1, 32'h0000_0055);
    wb(8'h04, 1'b1, 32'h0000_0011);
    wb(8'h0C, 1'b1, 32'h0000_00AA);
    wb(8'h08, 1'b1, 32'h0000_0086);
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk("control", 64'h8C, rd);
    wb(8'h14, 1'b0, 32'h0000_0000);
    chk("status", 64'h2, rd);
    // Reset in mid program cycle
    wb(8'h10, 1'b1, 32'h0000_0001);
    go(8'h84);
    wb(8'h0C, 1'b1, 32'h0000_0055);
    wb(8'h0C, 1'b1, 32'h0000_00AA);
    adr <= 8'h08;
    dat <= 32'h0000_0086;
    cyc <= 1'b1;
    repeat (5) @(posedge mclk);
    rstn <= 1'b0;
    cyc <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk("holding", 64'hFFFF_FFFF_FFFF_FFFF, fwd);
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk("control", 64'h88, rd & 64'hC8);
    wb(8'h1C, 1'b0, 32'h0000_0000);
    chk("unmapped", 64'h0, rd);
    test_done;
  end
endmodule // tb
